//--- design/occ_ctrl.sv
//
// Functional notes
// (R01) Controller sends calibration exit after each calibration command first.
// (R02) Controller programs mode register first and keeps termination sensible.
// (R03) Calibration field: 000 exit, 001 high, 010 low, 100 adjust, 111 default.
// (R04) Drive-high: DQ and DQS high, complementary strobe low.
// (R05) Drive-low: DQ and DQS low, complementary strobe high.
// (R06) Controller sets burst length four; each code is a four-beat burst.
// (R07) Controller drives the same code on all DQ, beat 0 first.
// (R08) Beat order is fixed regardless of burst type.
// (R09) Code steps pull-up and pull-down by one; zero and reserved do nothing.
// (R10) All DQ and strobe drivers share one strength setting.
// (R11) Sixteen steps, saturating at both ends; default anywhere in range.
// (R12) Adjust code is taken at AL plus CL minus one, old AL kept.
// (R13) Controller writes 000 in the field on later non-calibration writes.
// (R14) Drive outputs turn on and off tOIT after entry and exit.
// (R15) Termination pin switches termination on every data and strobe pin.
// (R16) Termination is off during self refresh.
// (R17) Termination value comes from bits A6 and A2, selecting one path.
// (R18) New termination value applies tMOD after the write.
// (R19) Controller meets tAOFD and holds termination low through tMOD.
// (R20) A9 to A7 is the calibration field; reduced strength disables it.
// (R21) Controller writes the register only when idle with CKE high.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Driver calibration and termination control of the memory device.
module occ_ctrl #(
    parameter int DQ_W = 8
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_srst,
    // Register bus.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Memory pins.
    input wire occ_pkg::occ_cmd_t i_cmd,
    input wire logic i_odt,
    input wire logic [DQ_W-1:0] i_dq,
    output logic [DQ_W-1:0] o_dq,
    output logic o_dq_oe,
    output logic o_dqs,
    output logic o_dqs_n,
    output logic o_dqs_oe,
    // Driver strength and termination.
    output logic [3:0] o_pu_step,
    output logic [3:0] o_pd_step,
    output logic o_term_on,
    output logic [1:0] o_rtt_sel
);
    // =================================================================
    // Parameter check.
    if (DQ_W < 1 || occ_pkg::OIT_CYC < 2) begin : g_bad_width
        $error("DQ_W must be at least one and tOIT two cycles.");
    end

    // =================================================================
    // Declarations.
    occ_pkg::occ_drv_t drv_reg;
    occ_pkg::occ_adj_t adj_reg;
    logic [31:0] cfg_reg;
    logic [2:0] cl_reg, al_reg, drv_mode_reg;
    logic [1:0] rtt_pend_reg, beat_reg;
    logic [3:0] adj_cnt_reg, code_reg;
    logic reduced_reg, selfref_reg, cke_prev_reg;
    logic mrs, mr_wr, emr1_wr, cal_ok, sr_entry, rtt_chg;
    logic [2:0] cal;
    logic [3:0] wl, code_full;
    logic apb_acc, sel_cfg, sel_stat;
    logic [31:0] rdata_next, stat_word;
    logic oit_start, oit_done, mod_done, drv_entry, drv_exit, drv_out;
    logic code_valid, code_take, set_def;
    logic [1:0] st_inc, st_dec;
    logic [3:0] st_def [2];
    logic [3:0] st_out [2];

    // =================================================================
    // Command decode.
    // A mode register write needs CKE high and chip select low.
    assign mrs = i_cmd.cke && !i_cmd.cs_n && !i_cmd.ras_n &&
        !i_cmd.cas_n && !i_cmd.we_n;
    assign mr_wr = mrs && i_cmd.ba == occ_pkg::BA_MR;
    assign emr1_wr = mrs && i_cmd.ba == occ_pkg::BA_EMR1;
    assign cal = i_cmd.addr[occ_pkg::CAL_LSB +: 3]; // R20
    // Calibration applies only at full strength.
    assign cal_ok = emr1_wr && !i_cmd.addr[occ_pkg::REDUCED_BIT]; // R20
    // Self refresh entry is a refresh command with CKE falling.
    assign sr_entry = cke_prev_reg && !i_cmd.cke && !i_cmd.cs_n &&
        !i_cmd.ras_n && !i_cmd.cas_n && i_cmd.we_n;
    assign rtt_chg = emr1_wr; // R18
    // Write latency uses the additive latency already programmed.
    assign wl = 4'(al_reg) + 4'(cl_reg) - 4'h1; // R12

    // Mode register copies, self refresh state and CKE history.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cl_reg <= 3'h3;
            al_reg <= 3'h0;
            reduced_reg <= 1'b0;
            selfref_reg <= 1'b0;
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= i_cmd.cke;
            if (mr_wr) cl_reg <= i_cmd.addr[occ_pkg::CL_LSB +: 3];
            if (emr1_wr) begin
                al_reg <= i_cmd.addr[occ_pkg::AL_LSB +: 3];
                reduced_reg <= i_cmd.addr[occ_pkg::REDUCED_BIT]; // R20
            end
            if (sr_entry) selfref_reg <= 1'b1;
            else if (i_cmd.cke) selfref_reg <= 1'b0;
        end
    end

    // =================================================================
    // Drive modes with tOIT turn-on and turn-off.
    assign drv_entry = cal_ok && (cal == occ_pkg::CAL_DRV1 ||
        cal == occ_pkg::CAL_DRV0); // R03
    assign drv_exit = emr1_wr && cal == occ_pkg::CAL_EXIT &&
        drv_reg != occ_pkg::DRV_IDLE; // R03
    assign oit_start = drv_entry || drv_exit;
    // Drivers stay on through the turn-off delay.
    assign drv_out = drv_reg == occ_pkg::DRV_ON ||
        drv_reg == occ_pkg::DRV_FALL; // R14

    occ_delay #(.W(occ_pkg::TMR_W)) u_oit (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_start(oit_start),
        .i_len(occ_pkg::TMR_W'(occ_pkg::OIT_CYC - 1)),
        .o_busy(),
        .o_done(oit_done)
    );

    // Drive sequence: outputs follow the mode once tOIT has run out.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            drv_reg <= occ_pkg::DRV_IDLE;
            drv_mode_reg <= occ_pkg::CAL_EXIT;
        end else if (drv_entry) begin
            drv_reg <= occ_pkg::DRV_RISE; // R14
            drv_mode_reg <= cal;
        end else if (drv_exit) begin
            drv_reg <= occ_pkg::DRV_FALL; // R14
        end else if (oit_done) begin
            unique case (drv_reg)
                occ_pkg::DRV_RISE: drv_reg <= occ_pkg::DRV_ON;
                occ_pkg::DRV_FALL: drv_reg <= occ_pkg::DRV_IDLE;
                occ_pkg::DRV_IDLE, occ_pkg::DRV_ON: drv_reg <= drv_reg;
            endcase
        end
    end

    // Pin levels: every DQ and strobe follows the one drive mode.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_dq <= '0;
            o_dq_oe <= 1'b0;
            o_dqs <= 1'b0;
            o_dqs_n <= 1'b1;
            o_dqs_oe <= 1'b0;
        end else begin
            o_dq_oe <= drv_out; // R14
            o_dqs_oe <= drv_out; // R14
            o_dq <= {DQ_W{drv_mode_reg == occ_pkg::CAL_DRV1}}; // R04 R05
            o_dqs <= drv_mode_reg == occ_pkg::CAL_DRV1; // R04 R05
            o_dqs_n <= drv_mode_reg != occ_pkg::CAL_DRV1; // R04 R05
        end
    end

    // =================================================================
    // Adjust mode: four beats taken from DQ 0 in fixed order.
    assign code_full = {i_dq[0], code_reg[2:0]};
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            adj_reg <= occ_pkg::ADJ_IDLE;
            adj_cnt_reg <= 4'h0;
            beat_reg <= 2'h0;
            code_reg <= 4'h0;
        end else begin
            unique case (adj_reg)
                occ_pkg::ADJ_IDLE: begin
                    if (cal_ok && cal == occ_pkg::CAL_ADJ) begin // R03
                        adj_reg <= occ_pkg::ADJ_WAIT;
                        adj_cnt_reg <= wl - 4'h1; // R12
                    end
                end
                occ_pkg::ADJ_WAIT: begin
                    adj_cnt_reg <= adj_cnt_reg - 4'h1;
                    if (adj_cnt_reg == 4'h0) begin
                        adj_reg <= occ_pkg::ADJ_BEAT;
                        code_reg <= {3'h0, i_dq[0]}; // R07
                        beat_reg <= 2'h1;
                    end
                end
                occ_pkg::ADJ_BEAT: begin
                    // Bit k holds beat k whatever the burst type.
                    code_reg[beat_reg] <= i_dq[0]; // R08
                    beat_reg <= beat_reg + 2'h1;
                    if (beat_reg == 2'(occ_pkg::BEATS - 1))
                        adj_reg <= occ_pkg::ADJ_IDLE;
                end
                default: adj_reg <= occ_pkg::ADJ_IDLE;
            endcase
        end
    end

    // Code decode: beat 0 lowers and beat 1 raises pull-up, beat 2
    // lowers and beat 3 raises pull-down; clashing pairs are reserved.
    assign code_take = adj_reg == occ_pkg::ADJ_BEAT &&
        beat_reg == 2'(occ_pkg::BEATS - 1);
    assign code_valid = !(code_full[0] && code_full[1]) &&
        !(code_full[2] && code_full[3]); // R09
    assign st_inc = {code_full[3], code_full[1]} & {2{code_valid &&
        code_take}}; // R09
    assign st_dec = {code_full[2], code_full[0]} & {2{code_valid &&
        code_take}}; // R09
    assign set_def = cal_ok && cal == occ_pkg::CAL_DEF; // R03
    assign st_def[0] = cfg_reg[occ_pkg::CFG_PU_LSB +: occ_pkg::STEP_W];
    assign st_def[1] = cfg_reg[occ_pkg::CFG_PD_LSB +: occ_pkg::STEP_W];

    // One shared setting per direction for every driver.
    for (genvar i = 0; i < 2; i++) begin : g_step // R10
        occ_step u_step (
            .i_mclk(i_mclk),
            .i_srst(i_srst),
            .i_set_def(set_def),
            .i_def(st_def[i]),
            .i_inc(st_inc[i]),
            .i_dec(st_dec[i]),
            .o_step(st_out[i])
        );
    end
    assign o_pu_step = st_out[0]; // R11
    assign o_pd_step = st_out[1]; // R11

    // =================================================================
    // Termination value update after tMOD and pin switching.
    occ_delay #(.W(occ_pkg::TMR_W)) u_mod (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_start(rtt_chg),
        .i_len(occ_pkg::TMR_W'(occ_pkg::MOD_CYC)),
        .o_busy(),
        .o_done(mod_done)
    );

    // The pin gates termination on all data and strobe pins.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rtt_pend_reg <= 2'h0;
            o_rtt_sel <= 2'h0;
            o_term_on <= 1'b0;
        end else begin
            if (emr1_wr)
                rtt_pend_reg <= {i_cmd.addr[occ_pkg::RTT_HI_BIT],
                    i_cmd.addr[occ_pkg::RTT_LO_BIT]}; // R17
            if (mod_done) o_rtt_sel <= rtt_pend_reg; // R18
            o_term_on <= i_odt && !selfref_reg && !sr_entry &&
                o_rtt_sel != 2'h0; // R15 R16
        end
    end

    // =================================================================
    // Register bus: one wait state, unmapped addresses answer an error.
    assign apb_acc = i_psel && i_penable && o_pready;
    assign sel_cfg = i_paddr == occ_pkg::CFG_OFF;
    assign sel_stat = i_paddr == occ_pkg::STAT_OFF;
    assign stat_word = {16'h0, reduced_reg, selfref_reg, o_rtt_sel,
        drv_reg == occ_pkg::DRV_ON, drv_mode_reg, o_pd_step, o_pu_step};
    assign rdata_next = sel_cfg ? cfg_reg : sel_stat ? stat_word : 32'h0;

    // Ready rises in the second access cycle and drops after the edge.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0;
            o_pslverr <= 1'b0;
            cfg_reg <= occ_pkg::CFG_RST;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_prdata <= rdata_next;
            o_pslverr <= i_psel && i_penable && !o_pready &&
                !sel_cfg && !(sel_stat && !i_pwrite);
            if (apb_acc && i_pwrite && sel_cfg) cfg_reg <= i_pwdata;
        end
    end

    // =================================================================
    // Checks.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    localparam int OIT_D = occ_pkg::OIT_CYC + 1;
    localparam int MOD_D = occ_pkg::MOD_CYC + 1;

    a_drive_high_level: assert property ( // R04
        drv_reg == occ_pkg::DRV_ON && drv_mode_reg == occ_pkg::CAL_DRV1
        |=> o_dq_oe && &o_dq && o_dqs && !o_dqs_n)
        else $error("Drive-high levels wrong.");
    a_drive_low_level: assert property ( // R05
        drv_reg == occ_pkg::DRV_ON && drv_mode_reg == occ_pkg::CAL_DRV0
        |=> o_dq_oe && o_dq == '0 && !o_dqs && o_dqs_n)
        else $error("Drive-low levels wrong.");
    a_drive_on_delay: assert property ( // R14
        drv_entry && drv_reg == occ_pkg::DRV_IDLE |->
        ##OIT_D o_dq_oe && !$past(o_dq_oe))
        else $error("Drive turn-on not at tOIT.");
    a_drive_off_delay: assert property ( // R14
        drv_exit |-> ##OIT_D !o_dq_oe && $past(o_dq_oe))
        else $error("Drive turn-off not at tOIT.");
    a_term_selfref: assert property ( // R16
        selfref_reg |=> !o_term_on)
        else $error("Termination on in self refresh.");
    a_rtt_update: assert property ( // R18
        emr1_wr ##1 !emr1_wr [*1] |-> ##(occ_pkg::MOD_CYC)
        o_rtt_sel == $past(rtt_pend_reg))
        else $error("Termination value not applied at tMOD.");
    a_default_load: assert property ( // R03
        set_def && !adj_reg[1] |=> o_pu_step == $past(st_def[0]) &&
        o_pd_step == $past(st_def[1]))
        else $error("Default strength not restored.");
    a_adjust_beats: assert property ( // R12
        adj_reg == occ_pkg::ADJ_WAIT && adj_cnt_reg == 4'h0 |=>
        adj_reg == occ_pkg::ADJ_BEAT [*3] ##1 adj_reg == occ_pkg::ADJ_IDLE)
        else $error("Adjust burst not four beats.");
    a_zero_code_hold: assert property ( // R09
        code_take && code_full == 4'h0 && !set_def |=>
        $stable(o_pu_step) && $stable(o_pd_step))
        else $error("Zero code changed strength.");
    a_reduced_no_cal: assert property ( // R20
        emr1_wr && i_cmd.addr[occ_pkg::REDUCED_BIT] && drv_reg ==
        occ_pkg::DRV_IDLE |=> drv_reg == occ_pkg::DRV_IDLE)
        else $error("Calibration entered at reduced strength.");
    a_apb_wait: assert property (
        i_psel && i_penable && !o_pready |=> o_pready)
        else $error("Bus answer late.");
endmodule : occ_ctrl
`default_nettype wire

//--- design/occ_ctrl_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- design/occ_delay.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// One-shot delay: o_done is high in the cycle i_len cycles after start.
module occ_delay #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_srst,
    // Start and length, length at least one.
    input wire logic i_start,
    input wire logic [W-1:0] i_len,
    // Status.
    output logic o_busy,
    output logic o_done
);
    logic [W-1:0] cnt_reg;

    // Expiry is seen in the last counted cycle.
    assign o_done = o_busy && cnt_reg == W'(1);

    // Counter restarts on every start request.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cnt_reg <= '0;
            o_busy <= 1'b0;
        end else if (i_start) begin
            cnt_reg <= i_len;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            cnt_reg <= cnt_reg - W'(1);
            o_busy <= !o_done;
        end
    end
endmodule : occ_delay
`default_nettype wire

//--- design/occ_pkg.sv
`default_nettype none
// =====================================================================
// Shared constants and types for driver calibration and termination.
package occ_pkg;
    // Command pins of the memory interface sampled on each clock edge.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [2:0] ba;
        logic [13:0] addr;
    } occ_cmd_t;

    // Drive mode sequence and adjust burst capture.
    typedef enum logic [1:0] {DRV_IDLE, DRV_RISE, DRV_ON, DRV_FALL} occ_drv_t;
    typedef enum logic [1:0] {ADJ_IDLE, ADJ_WAIT, ADJ_BEAT} occ_adj_t;

    // Bank address codes of the mode register writes.
    localparam logic [2:0] BA_MR = 3'h0;
    localparam logic [2:0] BA_EMR1 = 3'h1;
    // Field positions within the mode register address bits.
    localparam int CL_LSB = 4;
    localparam int AL_LSB = 3;
    localparam int CAL_LSB = 7;
    localparam int REDUCED_BIT = 1;
    localparam int RTT_HI_BIT = 6;
    localparam int RTT_LO_BIT = 2;
    // Calibration field codes.
    localparam logic [2:0] CAL_EXIT = 3'h0;
    localparam logic [2:0] CAL_DRV1 = 3'h1;
    localparam logic [2:0] CAL_DRV0 = 3'h2;
    localparam logic [2:0] CAL_ADJ = 3'h4;
    localparam logic [2:0] CAL_DEF = 3'h7;
    // Strength step range and the number of adjust beats.
    localparam int STEP_W = 4;
    localparam logic [3:0] STEP_MAX = 4'hf;
    localparam logic [3:0] STEP_MIN = 4'h0;
    localparam int BEATS = 4;
    // Register map of the control bus.
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [31:0] CFG_RST = 32'h00000088;
    localparam int CFG_PU_LSB = 0;
    localparam int CFG_PD_LSB = 4;
    // Timing: times in ns, cycle counts derived at the 8 ns clock.
    localparam int CLK_NS = 8;
    localparam int T_OIT_NS = 12;
    localparam int T_MOD_MIN_NS = 12;
    localparam int OIT_CYC = (T_OIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int MOD_CYC = (T_MOD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 8;
endpackage : occ_pkg
`default_nettype wire

//--- design/occ_step.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Saturating driver strength step, shared by all drivers of one kind.
module occ_step (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_srst,
    // Control.
    input wire logic i_set_def,
    input wire logic [3:0] i_def,
    input wire logic i_inc,
    input wire logic i_dec,
    // Current step.
    output logic [3:0] o_step
);
    logic [3:0] step_next;

    // Steps stop at either end of the range.
    assign step_next = i_set_def ? i_def :
        (i_inc && o_step != occ_pkg::STEP_MAX) ? o_step + 4'h1 :
        (i_dec && o_step != occ_pkg::STEP_MIN) ? o_step - 4'h1 : o_step;

    // Step register, reset to the middle of the range.
    always_ff @(posedge i_mclk) begin
        if (i_srst) o_step <= 4'h8;
        else o_step <= step_next;
    end

    a_step_saturates: assert property (@(posedge i_mclk) disable iff (i_srst) // R11
        !i_set_def && i_inc && o_step == occ_pkg::STEP_MAX |=>
        o_step == occ_pkg::STEP_MAX)
        else $error("Step moved past the top of its range.");
endmodule : occ_step
`default_nettype wire

//--- test/occ_mc_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Memory controller model: commands, termination pin and code beats.
module occ_mc_model (
    // Clock.
    input wire logic i_mclk,
    // Memory pins.
    output var occ_pkg::occ_cmd_t o_cmd,
    output logic o_odt,
    output logic [7:0] o_dq
);
    int al = 0;
    int cl = 3;
    logic [1:0] rtt = 2'h0;
    // Pins start idle with clock enable high.
    initial begin
        o_cmd = {4'hf, 1'b1, 3'h0, 14'h0};
        o_odt = 1'b0;
        o_dq = 8'h00;
    end
    // One command cycle, then deselect, so commands never crowd.
    task automatic cmd(input logic [2:0] b, input logic [13:0] a);
        @(posedge i_mclk);
        o_cmd <= {4'h0, 1'b1, b, a};
        @(posedge i_mclk);
        o_cmd <= {4'hf, 1'b1, 3'h0, 14'h0};
    endtask : cmd
    // Mode register with burst length four.
    task automatic mrs(input int c, input logic bt);
        cl = c;
        cmd(occ_pkg::BA_MR, {7'h0, 3'(c), bt, 3'h2});
    endtask : mrs
    // Extended register one; the termination pin drops a cycle early.
    task automatic emr1(input logic [2:0] f, input logic a1,
                        input logic [1:0] r);
        rtt = r;
        @(posedge i_mclk);
        o_odt <= 1'b0;
        cmd(occ_pkg::BA_EMR1, {4'h0, f, r[1], 3'(al), r[0], a1, 1'b0});
    endtask : emr1
    // Termination pin, raised only after the update window.
    task automatic odt(input logic v);
        @(posedge i_mclk);
        o_odt <= v;
    endtask : odt
    // Adjust entry, four beats at the write latency, then exit.
    task automatic adjust(input logic [3:0] c);
        emr1(occ_pkg::CAL_ADJ, 1'b0, rtt);
        repeat (al + cl - 2) @(posedge i_mclk);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) @(posedge i_mclk);
            o_dq <= {8{c[k]}};
        end
        @(posedge i_mclk);
        o_dq <= {8{~c[3]}};
        emr1(occ_pkg::CAL_EXIT, 1'b0, rtt);
    endtask : adjust
    // Self refresh keeps clock enable low until the exit.
    task automatic sr_enter;
        @(posedge i_mclk);
        o_cmd <= {4'h1, 1'b0, 3'h0, 14'h0};
        @(posedge i_mclk);
        o_cmd <= {4'hf, 1'b0, 3'h0, 14'h0};
    endtask : sr_enter
    task automatic sr_exit;
        @(posedge i_mclk);
        o_cmd <= {4'hf, 1'b1, 3'h0, 14'h0};
    endtask : sr_exit
endmodule : occ_mc_model
`default_nettype wire

//--- test/ocd_odt_calibration_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Self-checking bench for calibration and termination control.
module ocd_odt_calibration_control_tb;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    occ_pkg::occ_cmd_t cmd;
    logic odt;
    logic [7:0] dq_in;
    logic [7:0] dq_out;
    logic dq_oe;
    logic dqs;
    logic dqs_n;
    logic dqs_oe;
    logic [3:0] pu;
    logic [3:0] pd;
    logic term_on;
    logic [1:0] rtt_sel;
    logic [3:0] epu;
    logic [3:0] epd;
    logic [3:0] tab [0:6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h5, 4'h3};
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 88366;
    // Clock of 8 ns.
    initial begin
        forever #4 i_mclk = ~i_mclk;
    end
    occ_ctrl u_dut (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_cmd(cmd), .i_odt(odt), .i_dq(dq_in),
        .o_dq(dq_out), .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_n(dqs_n),
        .o_dqs_oe(dqs_oe), .o_pu_step(pu), .o_pd_step(pd),
        .o_term_on(term_on), .o_rtt_sel(rtt_sel)
    );
    occ_mc_model u_mc (.i_mclk(i_mclk), .o_cmd(cmd), .o_odt(odt),
                       .o_dq(dq_in));
    // Cuts a hang short.
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            complete_run;
        end
    end
    // =================================================================
    // Shared tasks.
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // APB transfer held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Saturating step expected from one code.
    function automatic logic [3:0] nstep(input logic [3:0] s,
                                         input logic up, input logic dn);
        if (up && !dn && s != occ_pkg::STEP_MAX) return s + 4'h1;
        if (dn && !up && s != occ_pkg::STEP_MIN) return s - 4'h1;
        return s;
    endfunction : nstep
    // Drive outputs keep the old state until the delay has run.
    task automatic drv_chk(input logic was, input logic on, input logic hi);
        repeat (occ_pkg::OIT_CYC - 1) @(posedge i_mclk);
        #1 chk("oe_hold", {30'h0, dq_oe, dqs_oe}, {30'h0, was, was});
        @(posedge i_mclk);
        #1 chk("oe", {30'h0, dq_oe, dqs_oe}, {30'h0, on, on});
        if (on) chk("pins", {22'h0, dq_out, dqs, dqs_n},
                    {22'h0, {8{hi}}, hi, ~hi});
    endtask : drv_chk
    task automatic step_chk;
        #1 chk("steps", {24'h0, pd, pu}, {24'h0, epd, epu});
    endtask : step_chk
    // =================================================================
    // Main sequence.
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic e;
        logic [3:0] c;
        repeat (3) @(posedge i_mclk);
        i_srst <= 1'b0;
        apb(1'b0, occ_pkg::CFG_OFF, 32'h0, r, e);
        chk("cfg_reset", r, occ_pkg::CFG_RST);
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        apb(1'b1, occ_pkg::STAT_OFF, 32'hffff, r, e);
        chk("ro_write", {31'h0, e}, 32'h1);
        apb(1'b0, occ_pkg::STAT_OFF, 32'h0, r, e);
        chk("status", {24'h0, r[7:0]}, 32'h88);
        u_mc.mrs(3, 1'b0);
        for (int k = 0; k < 2; k++) begin
            u_mc.emr1(k ? occ_pkg::CAL_DRV0 : occ_pkg::CAL_DRV1, 1'b0, 2'h0);
            drv_chk(1'b0, 1'b1, k == 0);
            u_mc.emr1(occ_pkg::CAL_EXIT, 1'b0, 2'h0);
            drv_chk(1'b1, 1'b0, 1'b0);
        end
        u_mc.emr1(occ_pkg::CAL_DRV1, 1'b1, 2'h0);
        drv_chk(1'b0, 1'b0, 1'b0);
        u_mc.emr1(occ_pkg::CAL_EXIT, 1'b0, 2'h0);
        d = $random(seed);
        apb(1'b1, occ_pkg::CFG_OFF, {24'h0, d[7:0]}, r, e);
        u_mc.emr1(occ_pkg::CAL_DEF, 1'b0, 2'h0);
        u_mc.emr1(occ_pkg::CAL_EXIT, 1'b0, 2'h0);
        epu = d[3:0];
        epd = d[7:4];
        step_chk;
        for (int i = 0; i < 80; i++) begin
            if (i == 60) begin
                u_mc.mrs(4, 1'b1);
                u_mc.al = 1;
                u_mc.emr1(occ_pkg::CAL_EXIT, 1'b0, 2'h0);
            end
            if (i < 7) c = tab[i];
            else if (i < 24) c = 4'h5;
            else if (i < 41) c = 4'h2;
            else if (i < 58) c = 4'h8;
            else c = tab[$unsigned($random(seed)) % 7];
            u_mc.adjust(c);
            epu = nstep(epu, c[1], c[0]);
            epd = nstep(epd, c[3], c[2]);
            step_chk;
        end
        for (int k = 1; k < 5; k++) begin
            u_mc.emr1(occ_pkg::CAL_EXIT, 1'b0, 2'(k));
            repeat (occ_pkg::MOD_CYC - 1) @(posedge i_mclk);
            #1 chk("rtt_old", {30'h0, rtt_sel}, 32'(k - 1) & 32'h3);
            @(posedge i_mclk);
            #1 chk("rtt_new", {30'h0, rtt_sel}, 32'(k) & 32'h3);
        end
        u_mc.emr1(occ_pkg::CAL_EXIT, 1'b0, 2'h2);
        repeat (4) @(posedge i_mclk);
        u_mc.odt(1'b1);
        repeat (2) @(posedge i_mclk);
        #1 chk("term_on", {31'h0, term_on}, 32'h1);
        u_mc.sr_enter;
        repeat (2) @(posedge i_mclk);
        #1 chk("term_sr", {31'h0, term_on}, 32'h0);
        u_mc.sr_exit;
        repeat (3) @(posedge i_mclk);
        #1 chk("term_back", {31'h0, term_on}, 32'h1);
        u_mc.odt(1'b0);
        repeat (2) @(posedge i_mclk);
        #1 chk("term_off", {31'h0, term_on}, 32'h0);
        complete_run;
    end
endmodule : ocd_odt_calibration_control_tb
`default_nettype wire
